//--- verilog/pattern_output_pkg.sv
// Constants, types and helpers for the pattern output next-data block
// ****************************************************************************
// What this block does
// - With groups 3 and 2 on one trigger, the group 3/2 next-data byte is one fully writable byte at its first index, cleared to zero.
// - With groups 3 and 2 on one trigger, the companion index reads all ones and ignores writes.
// - With groups 3 and 2 on different triggers, group 3 sits in the upper nibble of the first index, group 2 in the lower nibble of the second, other nibbles read ones.
// - On a group's selected compare-match, enabled bits of next_pattern_a are copied into port output bits 7 to 0.
// - A bit whose enable is clear is never transferred and keeps its output value unless software writes the port output data.
// - On the selected compare-match, enabled bits of next_pattern_b are copied into port output bits 15 to 8.
// - Bit n of pattern_enable_a gates the transfer into pin n, one enabling and zero disabling.
// - Bit n of pattern_enable_b gates the transfer into pin n+8, one enabling and zero disabling.
// - Both enable registers clear to zero on reset and keep their value through standby.
// - The trigger select register resets to all ones, channel 3 for every group, and keeps its value through standby.
// - A group's 2-bit select picks timer channel 0, 1, 2 or 3 as its compare-match source.
// - Select fields sit at bits 7-6 for group 3, 5-4 for group 2, 3-2 for group 1 and 1-0 for group 0.
// - Each group fires only on its own selected channel, independently of the others.
// - With groups 1 and 0 on one trigger, next_pattern_a holds group 1 in its upper and group 0 in its lower nibble.
// - Port output bits whose enable is set cannot be written by software.
// ****************************************************************************
package pattern_output_pkg;

  // ****************************************************************************
  // Register indices, byte address is four times the index
  // ****************************************************************************
  localparam logic [29:0] IDX_NEXT_B_FIRST  = 30'h5fffff4;
  localparam logic [29:0] IDX_NEXT_A_FIRST  = 30'h5fffff5;
  localparam logic [29:0] IDX_NEXT_B_SECOND = 30'h5fffff6;
  localparam logic [29:0] IDX_NEXT_A_SECOND = 30'h5fffff7;
  localparam logic [29:0] IDX_ENABLE_A      = 30'h5ffffe0;
  localparam logic [29:0] IDX_ENABLE_B      = 30'h5ffffe1;
  localparam logic [29:0] IDX_TRIG_SEL      = 30'h5ffffe2;
  localparam logic [29:0] IDX_PORT_DATA     = 30'h5ffffe3;

  // ****************************************************************************
  // Reset values and field layout
  // ****************************************************************************
  localparam logic [7:0]  RST_NEXT     = 8'h00;
  localparam logic [7:0]  RST_ENABLE   = 8'h00;
  localparam logic [7:0]  RST_TRIG_SEL = 8'hff;
  localparam logic [15:0] RST_PORT     = 16'h0000;
  localparam logic [7:0]  RSVD_BYTE    = 8'hff;
  localparam logic [3:0]  RSVD_NIBBLE  = 4'hf;
  localparam int          GRP_W        = 4;
  localparam int          SEL_W        = 2;
  localparam int          N_GRP        = 4;
  localparam int          N_CHAN       = 4;

  // ****************************************************************************
  // Bus encodings and state
  // ****************************************************************************
  localparam logic        HRESP_OKAY   = 1'b0;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_WRITE   = 2'b01,
    BUS_RD_WAIT = 2'b11,
    BUS_RD_DONE = 2'b10
  } bus_state_t;

  // Two groups share a byte when their select fields match
  function automatic logic same_trigger(input logic [7:0] sel, input logic upper_pair);
    same_trigger = upper_pair ? (sel[7:6] == sel[5:4]) : (sel[3:2] == sel[1:0]);
  endfunction

  // Readback of the first index of a next-data byte
  function automatic logic [7:0] first_view(input logic [7:0] r, input logic shared);
    first_view = shared ? r : {r[7:4], RSVD_NIBBLE};
  endfunction

  // Readback of the second index of a next-data byte
  function automatic logic [7:0] second_view(input logic [7:0] r, input logic shared);
    second_view = shared ? RSVD_BYTE : {RSVD_NIBBLE, r[3:0]};
  endfunction

endpackage

//--- verilog/pattern_group.sv
// One 4-bit output group: trigger select and bitwise gated transfer
`timescale 1ns/10ps
module pattern_group
  import pattern_output_pkg::*;
#(
  parameter int W = GRP_W
) (
  // Trigger
  input  wire logic [SEL_W-1:0]  sel,
  input  wire logic [N_CHAN-1:0] match_q,
  // Staged data
  input  wire logic [W-1:0]      enable,
  input  wire logic [W-1:0]      next_data,
  // Software write path
  input  wire logic              sw_write,
  input  wire logic [W-1:0]      sw_data,
  // Port bits
  input  wire logic [W-1:0]      current,
  output logic      [W-1:0]      next_out
);

  logic fire;

  always_comb begin
    fire = match_q[sel];
    for (int i = 0; i < W; i++) begin
      next_out[i] = current[i];
      if (enable[i]) begin
        if (fire) begin
          next_out[i] = next_data[i];
        end
      end else if (sw_write) begin
        next_out[i] = sw_data[i];
      end
    end
  end

endmodule // pattern_group

//--- verilog/pattern_output_next_data.sv
// Next-data staging, trigger select and port output data behind AHB-Lite
`timescale 1ns/10ps
module pattern_output_next_data
  import pattern_output_pkg::*;
(
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic      [31:0]         hrdata,
  // Timer compare-match pulses, one per channel
  input  wire logic [N_CHAN-1:0]   compare_match,
  // Pattern pins
  output logic      [15:0]         pattern_pins
);

  // ****************************************************************************
  // State
  // ****************************************************************************
  bus_state_t          state;
  bus_state_t          next_state;
  logic [29:0]         addr_idx;
  logic [29:0]         next_addr_idx;
  logic [31:0]         next_hrdata;
  logic [7:0]          next_pattern_a;
  logic [7:0]          next_pattern_b;
  logic [7:0]          pattern_enable_a;
  logic [7:0]          pattern_enable_b;
  logic [7:0]          trigger_select;
  logic [15:0]         port_output_data;
  logic [7:0]          next_next_pattern_a;
  logic [7:0]          next_next_pattern_b;
  logic [7:0]          next_pattern_enable_a;
  logic [7:0]          next_pattern_enable_b;
  logic [7:0]          next_trigger_select;
  logic [15:0]         next_port_output_data;
  logic [N_CHAN-1:0]   match_q;
  logic                accept;
  logic                wr_now;
  logic                shared_a;
  logic                shared_b;
  logic [7:0]          wbyte;
  logic [31:0]         read_mux;
  logic [15:0]         enable_all;
  logic [15:0]         next_all;

  assign hresp        = HRESP_OKAY;
  assign pattern_pins = port_output_data;
  assign enable_all   = {pattern_enable_b, pattern_enable_a};
  assign next_all     = {next_pattern_b, next_pattern_a};
  assign shared_a     = same_trigger(trigger_select, 1'b0);
  assign shared_b     = same_trigger(trigger_select, 1'b1);
  assign wbyte        = hwdata[7:0];

  // ****************************************************************************
  // Bus sequencing: writes zero wait, reads one wait state
  // ****************************************************************************
  always_comb begin
    accept        = hsel && htrans[1] && hready;
    wr_now        = (state == BUS_WRITE);
    hreadyout     = (state != BUS_RD_WAIT);
    next_addr_idx = accept ? haddr[31:2] : addr_idx;
    case (state)
      BUS_RD_WAIT: begin
        next_state = BUS_RD_DONE;
      end
      BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
        if (accept) begin
          next_state = hwrite ? BUS_WRITE : BUS_RD_WAIT;
        end else begin
          next_state = BUS_IDLE;
        end
      end
      default: begin
        next_state = BUS_IDLE;
      end
    endcase
    next_hrdata = (state == BUS_RD_WAIT) ? read_mux : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= BUS_IDLE;
      addr_idx <= '0;
      hrdata   <= READ_UNMAPPED;
    end else begin
      state    <= next_state;
      addr_idx <= next_addr_idx;
      hrdata   <= next_hrdata;
    end
  end

  // ****************************************************************************
  // Read decode
  // ****************************************************************************
  always_comb begin
    read_mux = READ_UNMAPPED;
    case (addr_idx)
      IDX_NEXT_B_FIRST: begin
        read_mux[7:0] = first_view(next_pattern_b, shared_b);
      end
      IDX_NEXT_B_SECOND: begin
        read_mux[7:0] = second_view(next_pattern_b, shared_b);
      end
      IDX_NEXT_A_FIRST: begin
        read_mux[7:0] = first_view(next_pattern_a, shared_a);
      end
      IDX_NEXT_A_SECOND: begin
        read_mux[7:0] = second_view(next_pattern_a, shared_a);
      end
      IDX_ENABLE_A: begin
        read_mux[7:0] = pattern_enable_a;
      end
      IDX_ENABLE_B: begin
        read_mux[7:0] = pattern_enable_b;
      end
      IDX_TRIG_SEL: begin
        read_mux[7:0] = trigger_select;
      end
      IDX_PORT_DATA: begin
        read_mux[15:0] = port_output_data;
      end
      default: begin
        read_mux = READ_UNMAPPED;
      end
    endcase
  end

  // ****************************************************************************
  // Register writes
  // ****************************************************************************
  always_comb begin
    next_next_pattern_a   = next_pattern_a;
    next_next_pattern_b   = next_pattern_b;
    next_pattern_enable_a = pattern_enable_a;
    next_pattern_enable_b = pattern_enable_b;
    next_trigger_select   = trigger_select;
    if (wr_now) begin
      case (addr_idx)
        IDX_NEXT_B_FIRST: begin
          if (shared_b) begin
            next_next_pattern_b = wbyte;
          end else begin
            next_next_pattern_b[7:4] = wbyte[7:4];
          end
        end
        IDX_NEXT_B_SECOND: begin
          if (!shared_b) begin
            next_next_pattern_b[3:0] = wbyte[3:0];
          end
        end
        IDX_NEXT_A_FIRST: begin
          if (shared_a) begin
            next_next_pattern_a = wbyte;
          end else begin
            next_next_pattern_a[7:4] = wbyte[7:4];
          end
        end
        IDX_NEXT_A_SECOND: begin
          if (!shared_a) begin
            next_next_pattern_a[3:0] = wbyte[3:0];
          end
        end
        IDX_ENABLE_A: begin
          next_pattern_enable_a = wbyte;
        end
        IDX_ENABLE_B: begin
          next_pattern_enable_b = wbyte;
        end
        IDX_TRIG_SEL: begin
          next_trigger_select = wbyte;
        end
        default: begin
          next_trigger_select = trigger_select;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      next_pattern_a   <= RST_NEXT;
      next_pattern_b   <= RST_NEXT;
      pattern_enable_a <= RST_ENABLE;
      pattern_enable_b <= RST_ENABLE;
      trigger_select   <= RST_TRIG_SEL;
    end else begin
      next_pattern_a   <= next_next_pattern_a;
      next_pattern_b   <= next_next_pattern_b;
      pattern_enable_a <= next_pattern_enable_a;
      pattern_enable_b <= next_pattern_enable_b;
      trigger_select   <= next_trigger_select;
    end
  end

  // ****************************************************************************
  // Compare-match capture and per-group transfer
  // ****************************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_q <= '0;
    end else begin
      match_q <= compare_match;
    end
  end

  for (genvar g = 0; g < N_GRP; g++) begin : grp
    pattern_group #(
      .W (GRP_W)
    ) u_group (
      .sel       (trigger_select[SEL_W*g +: SEL_W]),
      .match_q   (match_q),
      .enable    (enable_all[GRP_W*g +: GRP_W]),
      .next_data (next_all[GRP_W*g +: GRP_W]),
      .sw_write  (wr_now && (addr_idx == IDX_PORT_DATA)),
      .sw_data   (hwdata[GRP_W*g +: GRP_W]),
      .current   (port_output_data[GRP_W*g +: GRP_W]),
      .next_out  (next_port_output_data[GRP_W*g +: GRP_W])
    );
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_output_data <= RST_PORT;
    end else begin
      port_output_data <= next_port_output_data;
    end
  end

endmodule // pattern_output_next_data

//--- test/pattern_output_assertions.sv
// Concurrent checks on the ports of the pattern output next-data block
`timescale 1ns/10ps
module pattern_output_assertions
  import pattern_output_pkg::*;
(
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  // Triggers and pins
  input wire logic [3:0]  compare_match,
  input wire logic [15:0] pattern_pins
);
  logic        take, wr_dp, rd_dp, next_wr, next_rd;
  logic [29:0] idx, next_idx;
  logic [7:0]  sel, next_sel;
  logic [15:0] en, next_en, grp, prev, chg;
  logic [3:0]  match_q;
  // Shadow of select and enable as software wrote them
  always_comb begin
    take = hsel && htrans[1] && hready;
    next_wr = take && hwrite;
    next_rd = (take && !hwrite) || (rd_dp && !hreadyout);
    next_idx = take ? haddr[31:2] : idx;
    next_sel = (wr_dp && idx == IDX_TRIG_SEL) ? hwdata[7:0] : sel;
    next_en = en;
    if (wr_dp && idx == IDX_ENABLE_A) next_en[7:0] = hwdata[7:0];
    if (wr_dp && idx == IDX_ENABLE_B) next_en[15:8] = hwdata[7:0];
    for (int g = 0; g < N_GRP; g++) grp[4*g+:4] = {4{match_q[sel[2*g+:2]]}};
    chg = pattern_pins ^ prev;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {wr_dp, rd_dp, idx, sel, en, match_q, prev} <= {32'h0, RST_TRIG_SEL, 36'h0};
    else {wr_dp, rd_dp, idx, sel, en, match_q, prev} <=
      {next_wr, next_rd, next_idx, next_sel, next_en, compare_match, pattern_pins};
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_quiet; compare_match == 4'h0 ##1 !wr_dp; endsequence
  sequence s_rd_end; rd_dp && hreadyout; endsequence
  property p_idle; s_quiet |=> $stable(pattern_pins); endproperty
  a_idle: assert property (p_idle) else $error("pins moved with no cause");
  property p_off; !wr_dp |=> (chg & ~$past(en)) == 16'h0; endproperty
  a_off: assert property (p_off) else $error("disabled pin moved");
  property p_route; !wr_dp |=> (chg & ~$past(grp)) == 16'h0; endproperty
  a_route: assert property (p_route) else $error("group moved on foreign channel");
  property p_sw_ro; wr_dp && idx == IDX_PORT_DATA && match_q == 4'h0 |=> (chg & $past(en)) == 16'h0;
  endproperty
  a_sw_ro: assert property (p_sw_ro) else $error("enabled pin written by software");
  property p_sw_wr;
    wr_dp && idx == IDX_PORT_DATA |=> ((pattern_pins ^ 16'($past(hwdata))) & ~$past(en)) == 16'h0;
  endproperty
  a_sw_wr: assert property (p_sw_wr) else $error("disabled pin not written");
  property p_rd_sel; s_rd_end ##0 idx == IDX_TRIG_SEL |-> hrdata == {24'h0, sel}; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("select readback wrong");
  property p_rd_en; s_rd_end ##0 idx == IDX_ENABLE_B |-> hrdata == {24'h0, en[15:8]}; endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");
  property p_rd_pad;
    s_rd_end ##0 (idx == IDX_NEXT_B_SECOND && sel[7:6] == sel[5:4]) |-> hrdata == 32'hff;
  endproperty
  a_rd_pad: assert property (p_rd_pad) else $error("pad byte not all ones");
endmodule // pattern_output_assertions

//--- test/timer_match_model.sv
// Behavioural timer channels that raise compare-match pulses
`timescale 1ns/10ps
module timer_match_model (
  // Clock, reset, requests and pulses
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] fire,
  output logic      [3:0] compare_match
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) compare_match <= 4'h0;
    else compare_match <= fire;
  end
endmodule // timer_match_model

//--- test/test_pattern_output_next_data.sv
// Directed bench for the pattern output next-data block
`timescale 1ns/10ps
module test_pattern_output_next_data
  import pattern_output_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        hreadyout, hresp;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [3:0]  fire = 4'h0, compare_match;
  logic [15:0] pattern_pins, exp_pins;
  int          err_count = 0, checks_done = 0;
  pattern_output_next_data i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .compare_match(compare_match),
    .pattern_pins(pattern_pins));
  timer_match_model i_timer (.hclk(hclk), .hresetn(hresetn), .fire(fire),
    .compare_match(compare_match));
  initial forever #10 hclk = ~hclk;
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hs;
    for (int n = 0; n < 40; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    err_count++;
    $display("[ERR] %0t bus hang", $time);
    results();
  endtask
  // Single transfer; a read compares its data with d
  task automatic xfer(input logic w, input logic [29:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {i, 2'b00};
    hs();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    hs();
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    if (!w) chk(hrdata, d);
  endtask
  task automatic pulse(input logic [3:0] m, input logic [15:0] e);
    fire <= m;
    @(posedge hclk);
    fire <= 4'h0;
    repeat (3) @(posedge hclk);
    chk({16'h0, pattern_pins}, {16'h0, e});
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, IDX_ENABLE_B, 32'h0);
    xfer(1'b0, IDX_TRIG_SEL, 32'hff);
    xfer(1'b0, IDX_NEXT_A_FIRST, 32'h0);
    xfer(1'b0, 30'h10, 32'h0);
    xfer(1'b1, IDX_NEXT_B_FIRST, 32'ha5);
    xfer(1'b1, IDX_NEXT_B_SECOND, 32'h00);
    xfer(1'b0, IDX_NEXT_B_FIRST, 32'ha5);
    xfer(1'b0, IDX_NEXT_B_SECOND, 32'hff);
    xfer(1'b1, IDX_NEXT_A_FIRST, 32'hff);
    xfer(1'b1, IDX_ENABLE_A, 32'h3c);
    xfer(1'b1, IDX_ENABLE_B, 32'hc3);
    pulse(4'h1, 16'h0000);
    pulse(4'h8, 16'h813c);
    xfer(1'b1, IDX_PORT_DATA, 32'hffff);
    xfer(1'b0, IDX_PORT_DATA, 32'hbdff);
    xfer(1'b1, IDX_ENABLE_A, 32'hff);
    xfer(1'b1, IDX_ENABLE_B, 32'hff);
    xfer(1'b1, IDX_TRIG_SEL, 32'he4);
    xfer(1'b1, IDX_NEXT_B_FIRST, 32'h5f);
    xfer(1'b1, IDX_NEXT_B_SECOND, 32'hf6);
    xfer(1'b1, IDX_NEXT_A_FIRST, 32'h7f);
    xfer(1'b1, IDX_NEXT_A_SECOND, 32'hf8);
    xfer(1'b0, IDX_NEXT_B_FIRST, 32'h5f);
    xfer(1'b0, IDX_NEXT_B_SECOND, 32'hf6);
    exp_pins = 16'hbdff;
    for (int c = 0; c < N_CHAN; c++) begin
      exp_pins[4*c+:4] = 4'h8 - 4'(c);
      pulse(4'h1 << c, exp_pins);
    end
    results();
  end
endmodule // test_pattern_output_next_data
bind pattern_output_next_data pattern_output_assertions i_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .compare_match(compare_match), .pattern_pins(pattern_pins));
